// [rtl/hacrd_pkg.sv]
package hacrd_pkg;

  // Register offsets from the window base (byte addresses, 8-bit data).
  localparam logic [5:0] OFF_MASK_SET   = 6'h0a;
  localparam logic [5:0] OFF_MODE       = 6'h0b;
  localparam logic [5:0] OFF_PTR_CLEAR  = 6'h0c;
  localparam logic [5:0] OFF_TEMP_CLEAR = 6'h0d;
  localparam logic [5:0] OFF_MASK_CLEAR = 6'h0e;
  localparam logic [5:0] OFF_MASK_BIT   = 6'h0f;
  localparam logic [5:0] OFF_TRANSFER   = 6'h10;
  localparam logic [5:0] OFF_COMMAND    = 6'h11;
  localparam logic [5:0] OFF_CONTROL    = 6'h12;
  localparam logic [5:0] OFF_TARGET_ID  = 6'h13;
  localparam logic [5:0] OFF_AUX_STATUS = 6'h14;
  localparam logic [5:0] OFF_OWN_ID     = 6'h15;
  localparam logic [5:0] OFF_INT_CAUSE  = 6'h16;
  localparam logic [5:0] OFF_SEL_ID     = 6'h17;
  localparam logic [5:0] OFF_REQUEST    = 6'h09;
  localparam logic [5:0] OFF_UPPER_ADDR = 6'h23;
  localparam logic [5:0] OFF_OPTIONS    = 6'h2f;

  // Size of the decoded block inside its aligned window.
  localparam logic [5:0] WINDOW_USED    = 6'h30;

  // Field positions.
  localparam int MASK_SELECT_BIT = 0;
  localparam int MASK_VALUE_BIT  = 2;
  localparam int SOFT_REQ_BIT    = 2;

  // Reset values.
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic       RST_CHAN_MASK = 1'b1;

endpackage : hacrd_pkg

// [rtl/hacrd_top.sv]
`timescale 1ns/1ps
module hacrd_top (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Configuration switches, closed reads as 1.
  input  wire logic [2:0]  identity_switch,
  input  wire logic        arbitration_select_switch,
  input  wire logic [2:0]  interrupt_line_switch,
  input  wire logic        address_width_switch,
  input  wire logic        user_option_switch_0,
  input  wire logic        user_option_switch_1,
  input  wire logic [9:0]  base_match_switch,
  // Host I/O register port.
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  output logic             io_ack,
  // Values from the DMA and protocol engines.
  input  wire logic [7:0]  dma_temp_in,
  input  wire logic [7:0]  aux_status_in,
  input  wire logic [7:0]  int_cause_in,
  input  wire logic [7:0]  sel_id_in,
  input  wire logic [7:0]  transfer_in,
  input  wire logic        interrupt_event,
  // Configuration and control outputs.
  output logic [2:0]       own_bus_identity,
  output logic             serial_arbitration,
  output logic [7:0]       int_line_n,
  output logic             wide_address_path,
  output logic             dma_master_clear,
  output logic             byte_pointer_clear,
  output logic             dma_channel_mask,
  output logic [7:0]       dma_channel_mode,
  output logic             dma_soft_request,
  output logic [7:0]       dma_upper_address,
  output logic [7:0]       protocol_command,
  output logic [7:0]       protocol_control,
  output logic [7:0]       target_identity,
  output logic [7:0]       scsi_transfer_byte,
  output logic             transfer_write,
  output logic             dma_bus_master_only
);
  import hacrd_pkg::*;

  typedef struct packed {
    logic [19:0] sw_meta;
    logic [19:0] sw_sync;
    logic [7:0]  rdata;
    logic        ack;
    logic [2:0]  own_id;
    logic        serial;
    logic [7:0]  int_n;
    logic        wide;
    logic        mclr;
    logic        bpclr;
    logic        chan_mask;
    logic [7:0]  mode;
    logic        soft_req;
    logic [7:0]  upper;
    logic [7:0]  command;
    logic [7:0]  control;
    logic [7:0]  target;
    logic [7:0]  xfer;
    logic        xfer_wr;
    logic        master_only;
  } hacrd_state_t;

  hacrd_state_t st;
  hacrd_state_t next_st;

  logic [19:0] sw_raw;
  logic [2:0]  s_id;
  logic        s_arb;
  logic [2:0]  s_int;
  logic        s_wide;
  logic [1:0]  s_opt;
  logic [9:0]  s_base;
  logic        hit;
  logic [5:0]  offset;

  // Gather switches for the two-flop synchroniser.
  assign sw_raw = {base_match_switch, user_option_switch_1,
                   user_option_switch_0, address_width_switch,
                   interrupt_line_switch, arbitration_select_switch,
                   identity_switch};

  // Split the synchronised switch word; host has no path to change it.
  assign s_id   = st.sw_sync[2:0];
  assign s_arb  = st.sw_sync[3];
  assign s_int  = st.sw_sync[6:4];
  assign s_wide = st.sw_sync[7];
  assign s_opt  = st.sw_sync[9:8];
  assign s_base = st.sw_sync[19:10];

  // Base compare; narrow path ignores the top eight address lines.
  assign offset = io_addr[5:0];
  always_comb begin
    if (s_wide) begin
      hit = (io_addr[15:6] == s_base);
    end else begin
      hit = (io_addr[7:6] == s_base[1:0]);
    end
    hit = hit && (offset < WINDOW_USED);
  end

  // Next-state logic: decode, command strobes and register writes.
  always_comb begin
    next_st = st;
    next_st.sw_meta = sw_raw;
    next_st.sw_sync = st.sw_meta;
    next_st.own_id = s_id;
    next_st.serial = s_arb;
    next_st.wide = s_wide;
    next_st.master_only = 1'b1;
    // Pull low only the one line that the switches pick.
    for (int i = 0; i < 8; i++) begin
      next_st.int_n[i] = !(interrupt_event &&
                           (s_int == 3'(i)));
    end
    next_st.ack = hit && (io_rd || io_wr);
    next_st.rdata = RST_BYTE;
    next_st.mclr = 1'b0;
    next_st.bpclr = 1'b0;
    next_st.soft_req = 1'b0;
    next_st.xfer_wr = 1'b0;
    if (hit && io_wr) begin
      unique case (offset)
        // Mask set register uses its select bit only.
        OFF_MASK_SET: begin
          next_st.chan_mask = io_wdata[MASK_SELECT_BIT];
        end

        // Mode register keeps its two top bits at zero.
        OFF_MODE: begin
          next_st.mode = {2'b00, io_wdata[5:0]};
        end

        // A write here is a command; the data is thrown away.
        OFF_PTR_CLEAR: begin
          next_st.bpclr = 1'b1;
        end

        // Master clear returns the DMA channel mask and mode to their reset state; the upper address is kept.
        OFF_TEMP_CLEAR: begin
          next_st.mclr = 1'b1;
          next_st.chan_mask = RST_CHAN_MASK;
          next_st.mode = RST_BYTE;
          next_st.bpclr = 1'b1;
        end

        // Any data clears the channel mask.
        OFF_MASK_CLEAR: begin
          next_st.chan_mask = 1'b0;
        end

        // Only the mask value bit counts; the rest is ignored.
        OFF_MASK_BIT: begin
          next_st.chan_mask = io_wdata[MASK_VALUE_BIT];
        end

        // Byte for the bus engine, with a one-cycle write strobe.
        OFF_TRANSFER: begin
          next_st.xfer = io_wdata;
          next_st.xfer_wr = 1'b1;
        end

        // Protocol engine command byte.
        OFF_COMMAND: begin
          next_st.command = io_wdata;
        end

        // Protocol engine control byte.
        OFF_CONTROL: begin
          next_st.control = io_wdata;
        end

        // Identity of the device to be selected.
        OFF_TARGET_ID: begin
          next_st.target = io_wdata;
        end

        // Software DMA request, a one-cycle pulse.
        OFF_REQUEST: begin
          next_st.soft_req = io_wdata[SOFT_REQ_BIT];
        end

        // Top eight bits of the host memory address.
        OFF_UPPER_ADDR: begin
          next_st.upper = io_wdata;
        end

        // Read-only and unused offsets take no write.
        default: begin
        end
      endcase
    end
    if (hit && io_rd) begin
      unique case (offset)
        // Temporary value of the DMA engine.
        OFF_TEMP_CLEAR: begin
          next_st.rdata = dma_temp_in;
        end
        // Byte from the bus engine.
        OFF_TRANSFER: begin
          next_st.rdata = transfer_in;
        end
        // Command byte as last written.
        OFF_COMMAND: begin
          next_st.rdata = st.command;
        end
        // Control byte as last written.
        OFF_CONTROL: begin
          next_st.rdata = st.control;
        end
        // Target identity as last written.
        OFF_TARGET_ID: begin
          next_st.rdata = st.target;
        end
        // Status flags of the protocol engine.
        OFF_AUX_STATUS: begin
          next_st.rdata = aux_status_in;
        end
        // Own identity from the synchronised switches.
        OFF_OWN_ID: begin
          next_st.rdata = {5'h00, s_id};
        end
        // Interrupt cause of the protocol engine.
        OFF_INT_CAUSE: begin
          next_st.rdata = int_cause_in;
        end
        // Identity of the device that selected us.
        OFF_SEL_ID: begin
          next_st.rdata = sel_id_in;
        end
        // User option switches, meaning left to software.
        OFF_OPTIONS: begin
          next_st.rdata = {6'h00, s_opt};
        end
        // Anything else reads as zero.
        default: begin
          next_st.rdata = RST_BYTE;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.int_n <= 8'hff;
      st.chan_mask <= RST_CHAN_MASK;
    end else begin
      st <= next_st;
    end
  end

  // Host port answer straight from the state flops.
  assign io_rdata            = st.rdata;
  assign io_ack              = st.ack;

  // Configuration levels taken from the switches; int_line_n also follows interrupt_event on the line they pick.
  assign own_bus_identity    = st.own_id;
  assign serial_arbitration  = st.serial;
  assign int_line_n          = st.int_n;
  assign wide_address_path   = st.wide;

  // DMA engine commands and registers.
  assign dma_master_clear    = st.mclr;
  assign byte_pointer_clear  = st.bpclr;
  assign dma_channel_mask    = st.chan_mask;
  assign dma_channel_mode    = st.mode;
  assign dma_soft_request    = st.soft_req;
  assign dma_upper_address   = st.upper;

  // Protocol engine registers.
  assign protocol_command    = st.command;
  assign protocol_control    = st.control;
  assign target_identity     = st.target;
  assign scsi_transfer_byte  = st.xfer;
  assign transfer_write      = st.xfer_wr;

  // Host memory mastering is limited to DMA data moves.
  assign dma_bus_master_only = st.master_only;

endmodule : hacrd_top

// [test/hacrd_monitor.sv]
`timescale 1ns/1ps
module hacrd_monitor (
  // Clock, reset and base switches.
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [9:0]  base_match_switch,
  // Host port.
  input wire logic [15:0] io_addr,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_ack,
  // Outputs under watch.
  input wire logic [7:0]  int_line_n,
  input wire logic [2:0]  own_bus_identity,
  input wire logic        wide_address_path,
  input wire logic        dma_channel_mask,
  input wire logic [7:0]  dma_channel_mode,
  input wire logic        byte_pointer_clear
);
  import hacrd_pkg::*;
  logic [5:0] off;
  logic       hit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A request that falls inside the decoded window.
  assign off = io_addr[5:0];
  assign hit = (io_rd || io_wr) && off < WINDOW_USED && (wide_address_path
    ? io_addr[15:6] == base_match_switch
    : io_addr[7:6] == base_match_switch[1:0]);
  hit_ack_a: assert property (hit |=> io_ack)
    else $error("window access not answered");
  miss_quiet_a: assert property (!hit |=> !io_ack)
    else $error("answer without window access");
  ptr_clear_a: assert property (io_wr && hit && off == OFF_PTR_CLEAR
    |=> byte_pointer_clear) else $error("no byte pointer clear");
  full_clear_a: assert property (io_wr && hit && off == OFF_TEMP_CLEAR
    |=> dma_channel_mask && dma_channel_mode == 8'h00) else $error("no clear");
  mask_clear_a: assert property (io_wr && hit && off == OFF_MASK_CLEAR
    |=> !dma_channel_mask) else $error("mask not cleared");
  id_read_a: assert property (io_rd && hit && off == OFF_OWN_ID
    |=> io_rdata == {5'h00, own_bus_identity}) else $error("wrong identity");
  mode_top_a: assert property (dma_channel_mode[7:6] == 2'b00)
    else $error("mode top bits set");
  one_line_a: assert property ($onehot0(~int_line_n))
    else $error("several interrupt lines low");
endmodule : hacrd_monitor

bind hacrd_top hacrd_monitor u_hacrd_monitor (.*);

// [test/hacrd_host.sv]
`timescale 1ns/1ps
module hacrd_host (
  // Clock and answer from the block.
  input  wire logic        clk,
  input  wire logic        io_ack,
  input  wire logic [7:0]  io_rdata,
  // Request lines to the block.
  output logic      [15:0] io_addr,
  output logic             io_rd,
  output logic             io_wr,
  output logic      [7:0]  io_wdata
);
  // Idle request lines from time zero.
  initial begin
    {io_rd, io_wr, io_addr, io_wdata} = 26'h0000000;
  end
  // One byte: request held for one edge, answer read in the next cycle.
  task automatic xfer(input logic w, input logic [15:0] a,
    input logic [7:0] wd, output logic [7:0] rd, output logic ak);
    @(negedge clk);
    {io_rd, io_wr, io_addr, io_wdata} = {!w, w, a, wd};
    @(negedge clk);
    {rd, ak} = {io_rdata, io_ack};
    // Released address and data lines never keep the old value; both strobes go to zero.
    {io_rd, io_wr, io_addr, io_wdata} = {2'b00, ~a, ~wd};
  endtask : xfer
endmodule : hacrd_host

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import hacrd_pkg::*;
  logic clk, io_rd, io_wr, io_ack, ak, serial_arbitration, wide_address_path;
  logic dma_master_clear, byte_pointer_clear, dma_channel_mask;
  logic dma_soft_request, transfer_write, dma_bus_master_only;
  logic sys_rst = 1'b1, interrupt_event = 1'b0, address_width_switch = 1'b1;
  logic arbitration_select_switch = 1'b0, user_option_switch_0 = 1'b0;
  logic user_option_switch_1 = 1'b0;
  logic [2:0] identity_switch = 3'h0, interrupt_line_switch = 3'h0;
  logic [2:0] own_bus_identity;
  logic [9:0] base_match_switch = 10'h2a5;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, rd, int_line_n, dma_channel_mode;
  logic [7:0] dma_upper_address, protocol_command, protocol_control;
  logic [7:0] target_identity, scsi_transfer_byte, dma_temp_in = 8'h3c;
  logic [7:0] aux_status_in = 8'h81, int_cause_in = 8'h42;
  logic [7:0] sel_id_in = 8'h85, transfer_in = 8'h5a;
  wire  [15:0] base = {base_match_switch, 6'h00};
  int n_fail = 0, n_checks = 0, cycles = 0;
  hacrd_top u_hacrd_top (.*);
  hacrd_host u_hacrd_host (.*);
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      conclude();
    end
  end
  // Compares a seen value with the expected one.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Access a register by its offset from the selected base.
  task automatic acc(input logic w, input logic [5:0] off,
    input logic [7:0] wd);
    u_hacrd_host.xfer(w, base + {10'h000, off}, wd, rd, ak);
  endtask : acc
  // Prints the verdict and ends the run.
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // Reset, a sweep of switch settings, then register accesses.
  initial begin
    repeat (8) @(negedge clk);
    chk({dma_channel_mask, int_line_n[6:0]}, 8'hff);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      {identity_switch, interrupt_line_switch} = {i[2:0], i[2:0]};
      {user_option_switch_1, user_option_switch_0} = i[2:1];
      arbitration_select_switch = i[0];
      repeat (4) @(negedge clk);
      chk({5'h00, own_bus_identity}, 8'(i));
      chk({7'h00, serial_arbitration}, 8'(i % 2));
      acc(1'b0, OFF_OPTIONS, 8'h00);
      chk(rd, 8'(i / 2));
      interrupt_event = 1'b1;
      repeat (2) @(negedge clk);
      chk(int_line_n, ~(8'h01 << i));
      interrupt_event = 1'b0;
    end
    acc(1'b1, OFF_OWN_ID, 8'h02);
    acc(1'b0, OFF_OWN_ID, 8'h00);
    chk(rd, 8'h07);
    acc(1'b1, OFF_MODE, 8'hff);
    chk(dma_channel_mode, 8'h3f);
    acc(1'b1, OFF_MASK_CLEAR, 8'h5a);
    chk({7'h00, dma_channel_mask}, 8'h00);
    acc(1'b1, OFF_MASK_BIT, 8'h04);
    chk({7'h00, dma_channel_mask}, 8'h01);
    acc(1'b1, OFF_MASK_BIT, 8'hfb);
    chk({7'h00, dma_channel_mask}, 8'h00);
    acc(1'b1, OFF_PTR_CLEAR, 8'hff);
    chk({7'h00, byte_pointer_clear}, 8'h01);
    acc(1'b1, OFF_TEMP_CLEAR, 8'h00);
    chk({6'h00, dma_master_clear, byte_pointer_clear}, 8'h03);
    acc(1'b0, OFF_TEMP_CLEAR, 8'h00);
    chk(rd, 8'h3c);
    acc(1'b1, OFF_UPPER_ADDR, 8'ha7);
    chk(dma_upper_address, 8'ha7);
    acc(1'b1, OFF_COMMAND, 8'h96);
    chk(protocol_command, 8'h96);
    acc(1'b0, OFF_COMMAND, 8'h00);
    chk(rd, 8'h96);
    acc(1'b1, OFF_CONTROL, 8'h05);
    chk(protocol_control, 8'h05);
    acc(1'b1, OFF_TARGET_ID, 8'h03);
    chk(target_identity, 8'h03);
    acc(1'b1, OFF_TRANSFER, 8'hc3);
    chk(scsi_transfer_byte, 8'hc3);
    chk({7'h00, transfer_write}, 8'h01);
    acc(1'b1, OFF_REQUEST, 8'h04);
    chk({7'h00, dma_soft_request}, 8'h01);
    acc(1'b0, OFF_AUX_STATUS, 8'h00);
    chk(rd, 8'h81);
    acc(1'b0, OFF_INT_CAUSE, 8'h00);
    chk(rd, 8'h42);
    acc(1'b0, OFF_SEL_ID, 8'h00);
    chk(rd, 8'h85);
    acc(1'b0, OFF_TRANSFER, 8'h00);
    chk(rd, 8'h5a);
    chk({7'h00, dma_bus_master_only}, 8'h01);
    acc(1'b0, WINDOW_USED, 8'h00);
    chk({7'h00, ak}, 8'h00);
    u_hacrd_host.xfer(1'b1, base ^ 16'h800b, 8'h15, rd, ak);
    chk({ak, dma_channel_mode[6:0]}, 8'h00);
    address_width_switch = 1'b0;
    repeat (4) @(negedge clk);
    u_hacrd_host.xfer(1'b0, base ^ 16'h3f15, 8'h00, rd, ak);
    chk({rd[6:0], wide_address_path}, 8'h0e);
    conclude();
  end
endmodule : tb_top
